/* core/fopr_pkg.sv */
// Package of constants for the FIFO offset programming and retransmit controller.
package fopr_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] FOPR_CTRL_OFS = 8'h00;
  localparam logic [7:0] FOPR_STAT_OFS = 8'h04;
  localparam logic [7:0] FOPR_EOFS_OFS = 8'h08;
  localparam logic [7:0] FOPR_FOFS_OFS = 8'h0C;
  localparam logic [7:0] FOPR_RDBK_OFS = 8'h10;
  // Command register bit positions.
  localparam int FOPR_CMD_SERIAL = 0;
  localparam int FOPR_CMD_PWRITE = 1;
  localparam int FOPR_CMD_PREAD = 2;
  localparam int FOPR_CMD_RETX = 3;
  // Offset width and serial bit count of the attached organization.
  localparam int FOPR_OFS_W = 16;
  localparam logic [5:0] FOPR_SER_BITS = 6'h20;
  // Divider for the link clocks made from hclk (half period in hclk cycles).
  localparam logic [3:0] FOPR_DIV_HALF = 4'h4;
  // Status field positions.
  localparam int FOPR_ST_BUSY = 0;
  localparam int FOPR_ST_DONE = 1;
  localparam int FOPR_ST_EMPTY = 2;
  localparam int FOPR_ST_ORN = 3;
  localparam int FOPR_ST_PAE = 4;
  localparam int FOPR_ST_PAF = 5;
  localparam int FOPR_ST_HF = 6;
  // Sequencer states.
  typedef enum logic [2:0] {
    FOPR_IDLE = 3'b000,
    FOPR_SER = 3'b001,
    FOPR_PWR = 3'b010,
    FOPR_PRD = 3'b011,
    FOPR_RTX = 3'b100,
    FOPR_WAIT = 3'b101
  } fopr_state_e;
endpackage : fopr_pkg

/* core/fopr_sync.sv */
// Two-flop synchroniser bank for the device's status pins.
`timescale 1ns/10ps
`default_nettype none
module fopr_sync #(
  parameter int W = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // First stage; only the second stage reads it.
  logic [W-1:0] meta_q;
  // Both stages shift together on every clock.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : fopr_sync
`default_nettype wire

/* core/fopr_ctrl.sv */
// Host controller that programs, reads back and retransmits a deep FIFO.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R01: Serial bits shift empty LSB first, full MSB last.
// R02: Serial load sends the whole depth bit count.
// R03: Serial load always sends both offsets together.
// R04: Shift enable high means edges ignored.
// R05: Loading pauses and resumes with next bit.
// R06: Flags valid three clocks after serial load.
// R07: Readback only through the parallel output port.
// R08: Parallel writes go empty, full, empty again.
// R09: Never read and write offsets together.
// R10: Master reset rewinds both offset pointers.
// R11: Parallel programming may pause between registers.
// R12: Flags valid two clocks after parallel word.
// R13: Readback words appear on low output bits.
// R14: Readback resumes and overwrites output word.
// R15: Readback allowed in both timing modes.
// R16: Retransmit needs enables high, request low edge.
// R17: Two to D-2 words before retransmit.
// R18: D is depth, plus one in fallthrough.
// R19: Standard mode: empty flag marks setup end.
// R20: Fallthrough mode: output ready marks setup end.
// R21: Flags update shortly after retransmit setup.
// R22: Zero latency loads first word immediately.
// R23: Latency choice is sampled at master reset.
// R24: Programming method fixed at master reset.
// R25: Readback order matches parallel write order.
module fopr_ctrl
  import fopr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic write_clock,
  output logic read_clock,
  output logic serial_shift_clock,
  output logic serial_offset_input,
  output logic serial_shift_enable,
  output logic offset_load_select,
  output logic write_enable_n,
  output logic read_enable_n,
  output logic retransmit_request,
  output logic [fopr_pkg::FOPR_OFS_W-1:0] write_data_in,
  input wire logic [fopr_pkg::FOPR_OFS_W-1:0] read_data_out,
  input wire logic empty_flag_n,
  input wire logic prog_almost_empty_flag,
  input wire logic prog_almost_full_flag,
  input wire logic half_full_flag
);
  import fopr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave.
  ////////////////////////////////////////////////////////////////////////////////
  logic wr_pend_q;  // Write data phase pending.
  logic [7:0] addr_q;  // Latched address of the data phase.
  logic [FOPR_OFS_W-1:0] eofs_q;  // Empty offset to program.
  logic [FOPR_OFS_W-1:0] fofs_q;  // Full offset to program.
  logic [2*FOPR_OFS_W-1:0] rdbk_q;  // Empty and full offsets read back.
  logic [3:0] cmd_d;  // Command strobe from software.
  logic busy;  // Sequencer is working.
  logic done_q;  // Sticky completion flag.
  logic [3:0] st_sync;  // Synchronised device flags.
  wire addr_ok = hsel && htrans[1] && hready;
  wire wr_go = wr_pend_q && addr_q == FOPR_CTRL_OFS && !busy;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cmd_d = wr_go ? hwdata[3:0] : 4'h0;
  // Empty flag sits at bit 2 so software can watch retransmit setup end. R19
  wire [31:0] stat_w = {25'h0, st_sync[3], st_sync[2], st_sync[1], 1'b0,
                        st_sync[0], done_q, busy};
  // Read mux; unmapped words read as zero.
  assign hrdata = addr_q == FOPR_STAT_OFS ? stat_w :
                  addr_q == FOPR_EOFS_OFS ? {16'h0, eofs_q} :
                  addr_q == FOPR_FOFS_OFS ? {16'h0, fofs_q} :
                  addr_q == FOPR_RDBK_OFS ? rdbk_q : 32'h0;
  // Address phase capture and register writes.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h0;
      eofs_q <= 16'h0;
      fofs_q <= 16'h0;
    end
    else
    begin
      if (wr_pend_q && addr_q == FOPR_EOFS_OFS)
        eofs_q <= hwdata[15:0];
      if (wr_pend_q && addr_q == FOPR_FOFS_OFS)
        fofs_q <= hwdata[15:0];
      if (hready)
      begin
        wr_pend_q <= addr_ok && hwrite;
        addr_q <= addr_ok ? haddr[7:0] : 8'hFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link clock divider and synchronised status.
  ////////////////////////////////////////////////////////////////////////////////
  logic [3:0] div_q;  // Half period counter.
  logic lclk_q;  // Shared link clock level.
  wire tick = div_q == FOPR_DIV_HALF - 4'h1;
  wire rise = tick && !lclk_q;  // Enable marking the coming rising edge.
  wire fall = tick && lclk_q;  // Enable marking the coming falling edge.
  // One clock drives write, read and shift clocks of the device.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 4'h0;
      lclk_q <= 1'b0;
    end
    else
    begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
      if (tick)
        lclk_q <= !lclk_q;
    end
  end
  assign write_clock = lclk_q;
  assign read_clock = lclk_q;
  assign serial_shift_clock = lclk_q;
  fopr_sync #(.W(4)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({half_full_flag, prog_almost_full_flag, prog_almost_empty_flag,
               empty_flag_n}),
    .sync_out(st_sync)
  );
  logic [FOPR_OFS_W-1:0] rdo_s1_q;  // First stage of read data.
  logic [FOPR_OFS_W-1:0] rdo_q;  // Synchronised read data.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdo_s1_q <= 16'h0;
      rdo_q <= 16'h0;
    end
    else
    begin
      rdo_s1_q <= read_data_out;
      rdo_q <= rdo_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  ////////////////////////////////////////////////////////////////////////////////
  fopr_state_e state_q;  // Current state.
  logic [5:0] cnt_q;  // Bit or word counter.
  logic [2*FOPR_OFS_W-1:0] sh_q;  // Serial shift image, empty offset in low half.
  logic [3:0] wait_q;  // Settle edges still to wait.
  assign busy = state_q != FOPR_IDLE;
  wire ser_end = cnt_q == FOPR_SER_BITS;  // All serial bits are out.
  // Readback sample point: data settled two link edges after a read edge.
  wire rd_sample = state_q == FOPR_WAIT && rise && wait_q == 4'h1;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= FOPR_IDLE;
      cnt_q <= 6'h0;
      sh_q <= 32'h0;
      wait_q <= 4'h0;
      done_q <= 1'b0;
      rdbk_q <= 32'h0;
      serial_offset_input <= 1'b0;
      serial_shift_enable <= 1'b1;
      offset_load_select <= 1'b1;
      write_enable_n <= 1'b1;
      read_enable_n <= 1'b1;
      retransmit_request <= 1'b1;
      write_data_in <= 16'h0;
    end
    else
    begin
      if (wr_go && hwdata[4])
        done_q <= 1'b0;
      case (state_q)
        FOPR_IDLE:
        begin
          cnt_q <= 6'h0;
          // Only one command runs, so reads never overlap writes. R09
          if (cmd_d[FOPR_CMD_SERIAL])
          begin
            sh_q <= {fofs_q, eofs_q};  // R03
            state_q <= FOPR_SER;
          end
          else if (cmd_d[FOPR_CMD_PWRITE])
            state_q <= FOPR_PWR;
          else if (cmd_d[FOPR_CMD_PREAD])
            state_q <= FOPR_PRD;
          else if (cmd_d[FOPR_CMD_RETX])
            state_q <= FOPR_RTX;  // Software keeps two to D-2 words first. R17 R18
        end
        FOPR_SER:
        begin
          // Change pins on the falling edge; device samples on the rising one.
          if (fall)
          begin
            offset_load_select <= 1'b0;  // R01
            serial_shift_enable <= 1'b0;  // R04
            serial_offset_input <= sh_q[0];  // R01
            sh_q <= {1'b0, sh_q[31:1]};
            cnt_q <= cnt_q + 6'h1;
            if (ser_end)  // R02
            begin
              offset_load_select <= 1'b1;  // R05
              serial_shift_enable <= 1'b1;
              wait_q <= 4'h3;  // R06
              state_q <= FOPR_WAIT;
            end
          end
        end
        FOPR_PWR:
        begin
          if (fall)
          begin
            offset_load_select <= 1'b0;
            write_enable_n <= 1'b0;  // R08
            write_data_in <= cnt_q[0] ? fofs_q : eofs_q;  // R08
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == 6'h2)
            begin
              offset_load_select <= 1'b1;  // R11
              write_enable_n <= 1'b1;
              wait_q <= 4'h2;  // R12
              state_q <= FOPR_WAIT;
            end
          end
        end
        FOPR_PRD:
        begin
          // One read edge per word; empty then full. R25
          if (fall)
          begin
            offset_load_select <= 1'b0;  // R13
            read_enable_n <= 1'b0;  // R07
            cnt_q <= cnt_q + 6'h10;  // Mark a readback word in flight.
            wait_q <= 4'h2;
            state_q <= FOPR_WAIT;
          end
        end
        FOPR_RTX:
        begin
          // Enables are already high; request low across one read edge. R16
          if (fall)
          begin
            retransmit_request <= cnt_q != 6'h0;
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == 6'h1)
            begin
              wait_q <= 4'h3;  // R21
              state_q <= FOPR_WAIT;
            end
          end
        end
        FOPR_WAIT:
        begin
          // Drop the read enable after its single edge. R14
          if (fall)
          begin
            read_enable_n <= 1'b1;
            offset_load_select <= 1'b1;
          end
          if (rise)
            wait_q <= wait_q - 4'h1;
          // The wait is over; readback words are told apart by the counter mark.
          if (rd_sample)
          begin
            if (cnt_q == 6'h10)
            begin
              rdbk_q[15:0] <= rdo_q;  // R13
              cnt_q <= 6'h20;  // Fetch the full offset next.
              state_q <= FOPR_PRD;
            end
            else if (cnt_q == 6'h30)
            begin
              rdbk_q[31:16] <= rdo_q;  // R13
              done_q <= 1'b1;
              state_q <= FOPR_IDLE;
            end
            else
            begin
              done_q <= 1'b1;
              state_q <= FOPR_IDLE;
            end
          end
        end
        default:
          state_q <= FOPR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  ////////////////////////////////////////////////////////////////////////////////
  pin_change_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(write_data_in) |-> lclk_q == 1'b0)  // R08
    else $error("data changed while link clock high");
  no_overlap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(!write_enable_n && !read_enable_n))  // R09
    else $error("offset read and write at once");
  rt_enables_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !retransmit_request |-> write_enable_n && read_enable_n)  // R16
    else $error("retransmit with enables low");
  ser_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !serial_shift_enable |-> !offset_load_select)  // R04
    else $error("shift enable without load select");
  ser_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == FOPR_SER && fall && cnt_q == FOPR_SER_BITS) |=> serial_shift_enable)  // R02
    else $error("serial load did not stop at bit count");
  rt_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(retransmit_request) |-> !retransmit_request [*8] ##1 retransmit_request)  // R16
    else $error("retransmit request width wrong");
  pwr_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == FOPR_PWR && fall && cnt_q == 6'h2) |=> write_enable_n && offset_load_select)  // R11
    else $error("parallel write did not end");
  rd_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(read_enable_n) |-> !read_enable_n [*8] ##1 read_enable_n)  // R13
    else $error("read enable held too long");
  ser_cov: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == FOPR_SER ##1 state_q == FOPR_WAIT);
  pwr_cov: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == FOPR_PWR ##1 state_q == FOPR_WAIT);
  prd_cov: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(done_q) && cnt_q == 6'h30);
  rtx_cov: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(retransmit_request));
endmodule : fopr_ctrl
`default_nettype wire

/* bench/fopr_dev_model.sv */
// Behavioural model of the FIFO's offset registers, flags and retransmit setup.
`timescale 1ns/10ps
`default_nettype none
module fopr_dev_model
  import fopr_pkg::*;
(
  input wire logic master_reset_n,
  input wire logic serial_method,
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic serial_shift_clock,
  input wire logic serial_offset_input,
  input wire logic serial_shift_enable,
  input wire logic offset_load_select,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic retransmit_request,
  input wire logic [fopr_pkg::FOPR_OFS_W-1:0] write_data_in,
  output logic [fopr_pkg::FOPR_OFS_W-1:0] read_data_out,
  output logic empty_flag_n,
  output logic prog_almost_empty_flag,
  output logic prog_almost_full_flag,
  output logic half_full_flag,
  output logic [fopr_pkg::FOPR_OFS_W-1:0] empty_ofs,
  output logic [fopr_pkg::FOPR_OFS_W-1:0] full_ofs,
  output int shift_total,
  output int retx_count,
  output int proto_errs
);
  logic method_q; // Serial method strap, held from master reset.
  logic [2*FOPR_OFS_W-1:0] sr_q; // Serial shift register, first bit ends lowest.
  logic [5:0] bit_q; // Bits taken of the current set.
  logic wptr_q; // Offset write pointer; low selects the empty offset.
  logic rptr_q; // Offset read pointer; low selects the empty offset.
  logic set_q; // A complete serial set has landed.
  int vcnt; // Read edges since the set landed.
  int rt_wait; // Read edges left in retransmit setup.
  logic [FOPR_OFS_W-1:0] se_q, sf_q; // Offsets from the last complete serial set.
  logic [FOPR_OFS_W-1:0] pe_q, pf_q; // Offsets from parallel writes.
  logic pvld_q; // Both parallel offsets have been written.
  int pcnt; // Read edges since the parallel set completed.
  // The strapped method chooses which loader owns the offset registers.
  assign empty_ofs = method_q ? se_q : pe_q;
  assign full_ofs = method_q ? sf_q : pf_q;
  //////////////////////////////////////////////////////////////////////
  // Serial loading; a partial set never reaches the offset registers.
  always @(posedge serial_shift_clock or negedge master_reset_n)
  begin
    if (!master_reset_n)
    begin
      method_q <= serial_method;
      bit_q <= 6'h00;
      shift_total <= 0;
      set_q <= 1'b0;
    end
    else if (method_q && !offset_load_select && !serial_shift_enable)
    begin
      sr_q <= {serial_offset_input, sr_q[2*FOPR_OFS_W-1:1]};
      shift_total <= shift_total + 1;
      bit_q <= (bit_q == FOPR_SER_BITS - 6'h01) ? 6'h00 : bit_q + 6'h01;
      if (bit_q == FOPR_SER_BITS - 6'h01)
      begin
        {sf_q, se_q} <= {serial_offset_input, sr_q[2*FOPR_OFS_W-1:1]};
        set_q <= 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Parallel writes alternate between the empty and the full offset.
  always @(posedge write_clock or negedge master_reset_n)
  begin
    if (!master_reset_n)
    begin
      wptr_q <= 1'b0;
      pvld_q <= 1'b0;
    end
    else if (!method_q && !offset_load_select && !write_enable_n)
    begin
      if (!wptr_q)
        pe_q <= write_data_in;
      else
      begin
        pf_q <= write_data_in;
        pvld_q <= 1'b1;
      end
      wptr_q <= ~wptr_q;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Readback, flag validity and retransmit setup on the read clock.
  always @(posedge read_clock or negedge master_reset_n)
  begin
    if (!master_reset_n)
    begin
      rptr_q <= 1'b0;
      read_data_out <= '0;
      empty_flag_n <= 1'b0;
      prog_almost_empty_flag <= 1'b0;
      prog_almost_full_flag <= 1'b1;
      half_full_flag <= 1'b1;
      vcnt <= 0;
      pcnt <= 0;
      rt_wait <= 0;
      retx_count <= 0;
      proto_errs <= 0;
    end
    else
    begin
      if (!offset_load_select && !read_enable_n)
      begin
        read_data_out <= rptr_q ? full_ofs : empty_ofs;
        rptr_q <= ~rptr_q;
      end
      if (!offset_load_select && !read_enable_n && !write_enable_n)
        proto_errs <= proto_errs + 1;
      if (set_q && vcnt < 3)
        vcnt <= vcnt + 1;
      if (vcnt == 2)
      begin
        prog_almost_empty_flag <= 1'b1;
        prog_almost_full_flag <= 1'b1;
      end
      // Parallel offsets make the flags valid two edges after the last word.
      if (pvld_q && pcnt < 2)
        pcnt <= pcnt + 1;
      if (pcnt == 1)
      begin
        prog_almost_empty_flag <= 1'b1;
        prog_almost_full_flag <= 1'b1;
      end
      if (!retransmit_request && rt_wait == 0)
      begin
        if (!read_enable_n || !write_enable_n)
          proto_errs <= proto_errs + 1;
        empty_flag_n <= 1'b0;
        rt_wait <= 3;
        retx_count <= retx_count + 1;
      end
      else if (rt_wait != 0)
      begin
        rt_wait <= rt_wait - 1;
        empty_flag_n <= (rt_wait == 1);
      end
    end
  end
endmodule : fopr_dev_model
`default_nettype wire

/* bench/fopr_ctrl_tb.sv */
// Self-checking bench for the FIFO offset programming and retransmit controller.
`timescale 1ns/10ps
`default_nettype none
module fopr_ctrl_tb;
  import fopr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b1;
  logic strap = 1'b1; // Serial method strap for the next master reset.
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, write_clock, read_clock, serial_shift_clock;
  logic serial_offset_input, serial_shift_enable, offset_load_select;
  logic write_enable_n, read_enable_n, retransmit_request;
  logic [FOPR_OFS_W-1:0] write_data_in, read_data_out, m_empty, m_full;
  logic empty_flag_n, prog_almost_empty_flag, prog_almost_full_flag, half_full_flag;
  int shift_total, retx_count, proto_errs;
  int fail_count = 0;
  int samples_checked = 0;
  //////////////////////////////////////////////////////////////////////
  // Clock, design and device model.
  always #2 hclk = ~hclk;
  fopr_ctrl fopr_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .write_clock, .read_clock,
    .serial_shift_clock, .serial_offset_input, .serial_shift_enable, .offset_load_select,
    .write_enable_n, .read_enable_n, .retransmit_request, .write_data_in, .read_data_out,
    .empty_flag_n, .prog_almost_empty_flag, .prog_almost_full_flag, .half_full_flag);
  fopr_dev_model fopr_dev_model_i (.master_reset_n(hresetn), .serial_method(strap),
    .write_clock, .read_clock, .serial_shift_clock, .serial_offset_input,
    .serial_shift_enable, .offset_load_select, .write_enable_n, .read_enable_n,
    .retransmit_request, .write_data_in, .read_data_out, .empty_flag_n,
    .prog_almost_empty_flag, .prog_almost_full_flag, .half_full_flag,
    .empty_ofs(m_empty), .full_ofs(m_full), .shift_total, .retx_count, .proto_errs);
  //////////////////////////////////////////////////////////////////////
  // Compare, report and bus tasks.
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic give_up(input string nm);
    check(nm, 32'h0, 32'h1);
    finish_test();
  endtask : give_up
  // Waits for a rising edge with hready high, bounded.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      if (n++ > 50)
        give_up("bus wait");
      @(posedge hclk);
    end
  endtask : wait_ready
  // One single word transfer; read data lands in rd.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : ahb
  // Clears done, issues one command and polls until it completes.
  task automatic run_cmd(input int bitpos);
    int n;
    n = 0;
    ahb(1'b1, FOPR_CTRL_OFS, 32'h10);
    ahb(1'b1, FOPR_CTRL_OFS, 32'h1 << bitpos);
    rd = 32'h0;
    while (rd[FOPR_ST_DONE] !== 1'b1)
    begin
      if (n++ > 3000)
        give_up("command wait");
      ahb(1'b0, FOPR_STAT_OFS, 32'h0);
    end
  endtask : run_cmd
  task automatic do_reset(input logic s);
    strap <= s;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  //////////////////////////////////////////////////////////////////////
  // Serial load, readback and retransmit, then parallel load after reset.
  initial
  begin
    do_reset(1'b1);
    ahb(1'b1, FOPR_EOFS_OFS, 32'h1234);
    ahb(1'b1, FOPR_FOFS_OFS, 32'hABCD);
    run_cmd(FOPR_CMD_SERIAL);
    check("serial empty", 32'h1234, {16'h0, m_empty});
    check("serial full", 32'hABCD, {16'h0, m_full});
    check("serial bits", 32'h20, shift_total);
    ahb(1'b0, FOPR_STAT_OFS, 32'h0);
    check("flags", 32'h3, {30'h0, rd[FOPR_ST_PAF], rd[FOPR_ST_PAE]});
    run_cmd(FOPR_CMD_PREAD);
    ahb(1'b0, FOPR_RDBK_OFS, 32'h0);
    check("readback", 32'hABCD1234, rd);
    run_cmd(FOPR_CMD_PREAD);
    ahb(1'b0, FOPR_RDBK_OFS, 32'h0);
    check("readback again", 32'hABCD1234, rd);
    ahb(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h0, rd);
    run_cmd(FOPR_CMD_RETX);
    check("retransmits", 32'h1, retx_count);
    ahb(1'b0, FOPR_STAT_OFS, 32'h0);
    check("empty flag", 32'h1, {31'h0, rd[FOPR_ST_EMPTY]});
    do_reset(1'b0);
    ahb(1'b1, FOPR_EOFS_OFS, 32'h0055);
    ahb(1'b1, FOPR_FOFS_OFS, 32'h00AA);
    run_cmd(FOPR_CMD_PWRITE);
    check("parallel empty", 32'h55, {16'h0, m_empty});
    check("parallel full", 32'hAA, {16'h0, m_full});
    ahb(1'b0, FOPR_STAT_OFS, 32'h0);
    check("parallel flags", 32'h3, {30'h0, rd[FOPR_ST_PAF], rd[FOPR_ST_PAE]});
    run_cmd(FOPR_CMD_PREAD);
    ahb(1'b0, FOPR_RDBK_OFS, 32'h0);
    check("readback after reset", 32'h00AA0055, rd);
    check("protocol faults", 32'h0, proto_errs);
    finish_test();
  end
endmodule : fopr_ctrl_tb
`default_nettype wire
